// ---- hw/ircf_pkg.sv ----
// package: register map, field layout and types of the iso receive channel filter
package ircf_pkg;

  // ************************************************************
  // register map (byte addresses on the apb bus)
  // ************************************************************
  localparam logic [7:0] LOW_SET_OFFSET = 8'h78;
  localparam logic [7:0] LOW_CLEAR_OFFSET = 8'h7C;
  localparam logic [7:0] HIGH_SET_OFFSET = 8'h70;
  localparam logic [7:0] HIGH_CLEAR_OFFSET = 8'h74;

  // ************************************************************
  // field layout and reset values
  // ************************************************************
  localparam int LOW_CHAN_COUNT = 32;
  localparam int HIGH_CHAN_BASE = 32;
  localparam logic [31:0] LOW_MASK_RESET = 32'h0000_0000;
  localparam logic [31:0] HIGH_MASK_RESET = 32'h0000_0000;
  localparam logic [31:0] UNMAPPED_READ = 32'h0000_0000;

  // ************************************************************
  // carriers
  // ************************************************************
  typedef struct packed {
    logic [7:0] paddr;
    logic psel;
    logic penable;
    logic pwrite;
    logic [31:0] pwdata;
  } ircf_apb_req_t;

  typedef struct packed {
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
  } ircf_apb_rsp_t;

endpackage : ircf_pkg

// ---- hw/ircf_top.sv ----
// module: apb register bank holding the 64 isochronous receive channel enables
`timescale 1ns/10ps
module ircf_top (
  input wire logic core_clk,
  input wire logic resetn,
  input wire ircf_pkg::ircf_apb_req_t apb_req,
  output ircf_pkg::ircf_apb_rsp_t apb_rsp,
  output logic [63:0] rx_chan_enable,
  output logic rx_chan_enable_zero,
  output logic rx_chan_enable_thirty_one,
  output logic rx_chan_enable_thirty_two,
  output logic rx_chan_enable_forty_one
);

  // ************************************************************
  // mask storage
  // ************************************************************
  logic [31:0] low_mask;
  logic [31:0] high_mask;
  logic [31:0] next_low_mask;
  logic [31:0] next_high_mask;
  logic [31:0] prdata;
  logic [31:0] next_prdata;
  logic pready;
  logic next_pready;
  logic pslverr;
  logic next_pslverr;
  logic [63:0] chan_enable;
  logic [63:0] next_chan_enable;
  logic access;
  logic wr;
  logic hit;

  // one wait state: pready is registered, so a transfer's access phase lasts two cycles
  assign access = apb_req.psel && apb_req.penable && !pready;
  assign wr = access && apb_req.pwrite;

  always_comb begin
    hit = 1'b0;
    case (apb_req.paddr)
      ircf_pkg::LOW_SET_OFFSET,
      ircf_pkg::LOW_CLEAR_OFFSET,
      ircf_pkg::HIGH_SET_OFFSET,
      ircf_pkg::HIGH_CLEAR_OFFSET: begin
        hit = 1'b1;
      end
      default: begin
        hit = 1'b0;
      end
    endcase
  end

  // ************************************************************
  // set / clear write logic
  // ************************************************************
  always_comb begin
    next_low_mask = low_mask;
    next_high_mask = high_mask;
    if (wr) begin
      case (apb_req.paddr)
        ircf_pkg::LOW_SET_OFFSET: begin
          next_low_mask = low_mask | apb_req.pwdata;
        end
        ircf_pkg::LOW_CLEAR_OFFSET: begin
          next_low_mask = low_mask & ~apb_req.pwdata;
        end
        ircf_pkg::HIGH_SET_OFFSET: begin
          next_high_mask = high_mask | apb_req.pwdata;
        end
        ircf_pkg::HIGH_CLEAR_OFFSET: begin
          next_high_mask = high_mask & ~apb_req.pwdata;
        end
        default: begin
          next_low_mask = low_mask;
        end
      endcase
    end
  end

  // ************************************************************
  // read path and handshake
  // ************************************************************
  always_comb begin
    next_pready = access;
    next_pslverr = access && !hit;
    next_prdata = ircf_pkg::UNMAPPED_READ;
    if (access && !apb_req.pwrite) begin
      case (apb_req.paddr)
        // both addresses of a pair read back the stored mask
        ircf_pkg::LOW_SET_OFFSET,
        ircf_pkg::LOW_CLEAR_OFFSET: begin
          next_prdata = low_mask;
        end
        ircf_pkg::HIGH_SET_OFFSET,
        ircf_pkg::HIGH_CLEAR_OFFSET: begin
          next_prdata = high_mask;
        end
        default: begin
          next_prdata = ircf_pkg::UNMAPPED_READ;
        end
      endcase
    end
  end

  // ************************************************************
  // channel enable vector
  // ************************************************************
  // registered copy keeps every output straight from a flip-flop; enables change in the same cycle as the mask
  for (genvar n = 0; n < ircf_pkg::LOW_CHAN_COUNT; n++) begin : g_chan
    always_comb begin
      next_chan_enable[n] = next_low_mask[n];
      next_chan_enable[ircf_pkg::HIGH_CHAN_BASE + n] = next_high_mask[n];
    end
  end

  // masks reset to zero for determinism, yet software still clears them before use
  always_ff @(posedge core_clk) begin
    if (!resetn) begin
      low_mask <= ircf_pkg::LOW_MASK_RESET;
      high_mask <= ircf_pkg::HIGH_MASK_RESET;
      chan_enable <= {ircf_pkg::HIGH_MASK_RESET, ircf_pkg::LOW_MASK_RESET};
      prdata <= ircf_pkg::UNMAPPED_READ;
      pready <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      low_mask <= next_low_mask;
      high_mask <= next_high_mask;
      chan_enable <= next_chan_enable;
      prdata <= next_prdata;
      pready <= next_pready;
      pslverr <= next_pslverr;
    end
  end

  assign apb_rsp.prdata = prdata;
  assign apb_rsp.pready = pready;
  assign apb_rsp.pslverr = pslverr;
  assign rx_chan_enable = chan_enable;
  assign rx_chan_enable_zero = chan_enable[0];
  assign rx_chan_enable_thirty_one = chan_enable[31];
  assign rx_chan_enable_thirty_two = chan_enable[32];
  assign rx_chan_enable_forty_one = chan_enable[41];

endmodule : ircf_top

// ---- test/ircf_assertions.sv ----
// checker: apb answer timing and channel mask update relations
`timescale 1ns/10ps
module ircf_chk (
  input wire logic core_clk,
  input wire logic resetn,
  input wire ircf_pkg::ircf_apb_req_t apb_req,
  input wire ircf_pkg::ircf_apb_rsp_t apb_rsp,
  input wire logic [63:0] rx_chan_enable,
  input wire logic rx_chan_enable_zero,
  input wire logic rx_chan_enable_thirty_one,
  input wire logic rx_chan_enable_thirty_two,
  input wire logic rx_chan_enable_forty_one
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (!resetn);
  wire logic tk = apb_req.psel & apb_req.penable & !apb_rsp.pready;
  wire logic [31:0] lo = rx_chan_enable[31:0];
  sequence s_wr(logic [7:0] o);
    tk && apb_req.pwrite && apb_req.paddr == o;
  endsequence
  property p_rdy; tk |=> apb_rsp.pready ##1 !apb_rsp.pready; endproperty
  a_rdy: assert property (p_rdy) else $error("pready timing");
  property p_set; s_wr(8'h78) |=> lo == ($past(lo) | $past(apb_req.pwdata)); endproperty
  a_set: assert property (p_set) else $error("set write");
  property p_clr; s_wr(8'h7C) |=> lo == ($past(lo) & ~$past(apb_req.pwdata)); endproperty
  a_clr: assert property (p_clr) else $error("clear write");
  property p_hold; !(tk && apb_req.pwrite) |=> $stable(rx_chan_enable); endproperty
  a_hold: assert property (p_hold) else $error("mask changed");
  property p_sep; s_wr(8'h70) |=> $stable(lo); endproperty
  a_sep: assert property (p_sep) else $error("low mask hit");
  property p_lo; rx_chan_enable_zero == lo[0] && rx_chan_enable_thirty_one == lo[31]; endproperty
  a_lo: assert property (p_lo) else $error("low copies");
  property p_hi;
    rx_chan_enable_thirty_two == rx_chan_enable[32] &&
      rx_chan_enable_forty_one == rx_chan_enable[41];
  endproperty
  a_hi: assert property (p_hi) else $error("high copies");
endmodule : ircf_chk
bind ircf_top ircf_chk u_chk (.core_clk(core_clk), .resetn(resetn), .apb_req(apb_req),
  .apb_rsp(apb_rsp), .rx_chan_enable(rx_chan_enable),
  .rx_chan_enable_zero(rx_chan_enable_zero),
  .rx_chan_enable_thirty_one(rx_chan_enable_thirty_one),
  .rx_chan_enable_thirty_two(rx_chan_enable_thirty_two),
  .rx_chan_enable_forty_one(rx_chan_enable_forty_one));

// ---- test/ircf_bench.sv ----
// bench: channel mask programming over apb
`timescale 1ns/10ps
module ircf_bench;
  typedef struct {logic [7:0] a; logic [31:0] d; logic [63:0] e;} ircf_row_t;
  logic core_clk = 1'h0;
  logic resetn = 1'h0;
  ircf_pkg::ircf_apb_req_t req = '0;
  ircf_pkg::ircf_apb_rsp_t rsp;
  logic [63:0] en;
  logic c0, c31, c32, c41, err;
  logic [31:0] rd;
  int n_mismatch = 0, cmp_count = 0, cyc = 0;
  // clears come first although the masks reset to zero
  ircf_row_t rows [7] = '{'{8'h7C, 32'hFFFFFFFF, 64'h0}, '{8'h74, 32'hFFFFFFFF, 64'h0},
    '{8'h78, 32'h1, 64'h1}, '{8'h78, 32'h80000000, 64'h80000001},
    '{8'h70, 32'h201, 64'h20180000001}, '{8'h7C, 32'h1, 64'h20180000000},
    '{8'h74, 32'h200, 64'h180000000}};
  ircf_top dut (.core_clk(core_clk), .resetn(resetn), .apb_req(req), .apb_rsp(rsp),
    .rx_chan_enable(en), .rx_chan_enable_zero(c0), .rx_chan_enable_thirty_one(c31),
    .rx_chan_enable_thirty_two(c32), .rx_chan_enable_forty_one(c41));
  initial forever #2 core_clk = ~core_clk;
  always @(posedge core_clk) begin
    cyc++;
    if (cyc == 1000) begin
      n_mismatch++;
      report_and_stop();
    end
  end
  task chk(input string n, input logic [63:0] e, input logic [63:0] g);
    cmp_count++;
    if (g !== e) begin
      n_mismatch++;
      $display("ERROR %s expected %h seen %h", n, e, g);
    end
  endtask : chk
  // called just after a rising edge; answer taken at the edge that sees pready high
  task apb(input logic [7:0] a, input logic w, input logic [31:0] d);
    req.paddr <= a;
    req.pwrite <= w;
    req.pwdata <= d;
    req.psel <= 1'h1;
    req.penable <= 1'h0;
    @(posedge core_clk);
    req.penable <= 1'h1;
    @(posedge core_clk);
    while (rsp.pready !== 1'h1) @(posedge core_clk);
    rd = rsp.prdata;
    err = rsp.pslverr;
    req.psel <= 1'h0;
    req.penable <= 1'h0;
    // one idle cycle so the next call never reassigns psel in this time step
    @(posedge core_clk);
  endtask : apb
  task report_and_stop;
    $display("mismatches %0d comparisons %0d", n_mismatch, cmp_count);
    if (n_mismatch == 0 && cmp_count > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask : report_and_stop
  initial begin
    repeat (4) @(posedge core_clk);
    resetn <= 1'h1;
    @(posedge core_clk);
    foreach (rows[i]) begin
      apb(rows[i].a, 1'h1, rows[i].d);
      chk("enable", rows[i].e, en);
      apb(rows[i].a, 1'h0, 32'h0);
      chk("prdata", rows[i].a[3] ? rows[i].e[31:0] : rows[i].e[63:32], rd);
    end
    chk("copies", 4'h6, {c41, c32, c31, c0});
    apb(8'h40, 1'h1, 32'hFFFFFFFF);
    chk("pslverr", 1'h1, err);
    chk("unmapped", rows[6].e, en);
    apb(8'h40, 1'h0, 32'h0);
    chk("unmapped_read", 32'h0, rd);
    chk("read_pslverr", 1'h1, err);
    report_and_stop();
  end
endmodule : ircf_bench
